// ==== rtl/crg_pkg.sv ====
// package for the controller ready gate: register map, field layout, types
// assumes a 32-bit apb master and a single 200 MHz clock
package crg_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CRG_OFF_CTRL    = 8'h00;
  localparam logic [7:0] CRG_OFF_STATUS  = 8'h04;
  localparam logic [7:0] CRG_OFF_IRQ_ST  = 8'h08;
  localparam logic [7:0] CRG_OFF_IRQ_MSK = 8'h0c;
  localparam logic [7:0] CRG_OFF_PARAM   = 8'h10;
  localparam logic [7:0] CRG_OFF_OUTPUTS = 8'h14;
  localparam logic [7:0] CRG_OFF_SETTING = 8'h18;

  // ==========================================================
  // field positions and widths
  localparam int CRG_CTRL_MODE_BIT = 0;
  localparam int CRG_SET_BIT       = 0;
  localparam int CRG_IRQ_W         = 4;
  localparam int CRG_IRQ_RISE      = 0;
  localparam int CRG_IRQ_FALL      = 1;
  localparam int CRG_IRQ_START_ERR = 2;
  localparam int CRG_IRQ_PARAM_REF = 3;
  localparam int CRG_OUT_W         = 16;
  localparam int CRG_PARAM_W       = 32;

  // ==========================================================
  // reset values
  localparam logic [31:0]        CRG_PARAM_RST = 32'h0000_0000;
  localparam logic [CRG_OUT_W-1:0] CRG_OUT_RST  = 16'h0000;
  localparam logic [CRG_IRQ_W-1:0] CRG_MSK_RST  = 4'h0;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    CRG_ST_OFF   = 4'b0001,
    CRG_ST_DEFER = 4'b0010,
    CRG_ST_CLEAR = 4'b0100,
    CRG_ST_RUN   = 4'b1000
  } crg_state_t;

  typedef struct packed {
    logic run_switch;
    logic deferred;
    logic test_mode;
    logic motion_enable;
    logic ready_complete;
    logic host_ready;
  } crg_status_t;
endpackage

// ==== rtl/crg_gate.sv ====
// controller ready gate: host-ready flag sequencing behind an apb slave
// assumes run switch arrives asynchronously; test mode and axis-busy come
// from logic on pclk
//
// Summary of operation
// - All relay-like state clears at every reset; nothing is retained.
// - Positioning, home return and jog are enabled only while ready is high.
// - Test mode blocks motion even with ready high.
// - Parameter writes are accepted only while ready is low, else refused.
// - Ready rising clears the aux-code store, sets complete and starts auto programs.
// - A moving axis at ready rise raises an error and skips rise processing.
// - Ready rising in test mode defers processing until test mode ends with ready high.
// - Ready falling clears complete, stops axes, halts programs, zeroes outputs.
// - A setting picks which condition asserts ready; default is the switch.
// - Default: ready follows switch stop-to-run (incl. power-up in run) and run-to-stop.
// - Alternative: with switch in run, setting bit 0 going 0 to 1 asserts ready.
// - Alternative: setting bit 0 going 1 to 0 in run, or switch to stop, clears ready.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module crg_gate
  import crg_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 run_switch,
  input  wire logic                 test_mode_flag,
  input  wire logic                 axis_busy,
  output logic                      host_ready_flag,
  output logic                      motion_ready_complete_flag,
  output logic                      motion_enable,
  output logic                      mcode_clear,
  output logic                      auto_start,
  output logic                      decel_stop,
  output logic                      prog_halt,
  output logic [CRG_OUT_W-1:0]      real_output_points,
  output logic [CRG_PARAM_W-1:0]    fixed_param,
  output logic                      irq
);

  // ==========================================================
  // switch synchroniser
  logic sw_meta_reg;
  logic sw_sync_reg;
  logic sw_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_reg <= 1'b0;
      sw_sync_reg <= 1'b0;
    end else if (clk_en) begin
      sw_meta_reg <= run_switch;
      sw_sync_reg <= sw_meta_reg;
    end
  end

  logic sw_rise;
  logic sw_fall;
  assign sw_rise = sw_sync_reg & ~sw_prev_reg;
  assign sw_fall = ~sw_sync_reg & sw_prev_reg;

  // ==========================================================
  // apb decode
  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic addr_hit;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & pready;
  assign rd_acc   = setup_ph & ~pwrite;
  assign addr_hit = (paddr == CRG_OFF_CTRL)    || (paddr == CRG_OFF_STATUS) ||
                    (paddr == CRG_OFF_IRQ_ST)  || (paddr == CRG_OFF_IRQ_MSK) ||
                    (paddr == CRG_OFF_PARAM)   || (paddr == CRG_OFF_OUTPUTS) ||
                    (paddr == CRG_OFF_SETTING);

  // ==========================================================
  // software registers
  logic                   mode_alt_reg;
  logic                   setting_reg;
  logic                   setting_prev_reg;
  logic [CRG_IRQ_W-1:0]   irq_mask_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_alt_reg <= 1'b0;
      setting_reg  <= 1'b0;
      irq_mask_reg <= CRG_MSK_RST;
    end else if (clk_en && wr_acc) begin
      if (paddr == CRG_OFF_CTRL) begin
        mode_alt_reg <= pwdata[CRG_CTRL_MODE_BIT];
      end
      if (paddr == CRG_OFF_SETTING) begin
        setting_reg <= pwdata[CRG_SET_BIT];
      end
      if (paddr == CRG_OFF_IRQ_MSK) begin
        irq_mask_reg <= pwdata[CRG_IRQ_W-1:0];
      end
    end
  end

  logic set_rise;
  logic set_fall;
  assign set_rise = setting_reg & ~setting_prev_reg;
  assign set_fall = ~setting_reg & setting_prev_reg;

  // ==========================================================
  // host ready flag
  logic host_ready_reg;
  logic ready_next;
  logic ready_prev_reg;

  always_comb begin
    ready_next = host_ready_reg;
    if (!mode_alt_reg) begin
      if (sw_rise) begin
        ready_next = 1'b1;
      end else if (sw_fall) begin
        ready_next = 1'b0;
      end
    end else begin
      if (sw_fall) begin
        ready_next = 1'b0;
      end else if (sw_sync_reg && set_rise) begin
        ready_next = 1'b1;
      end else if (sw_sync_reg && set_fall) begin
        ready_next = 1'b0;
      end
    end
  end

  // cleared at every reset, nothing retained
  // prev values for the edge compares; prev switch starts at stop
  // so power-up in run reads as a stop-to-run move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_ready_reg   <= 1'b0;
      sw_prev_reg      <= 1'b0;
      setting_prev_reg <= 1'b0;
      ready_prev_reg   <= 1'b0;
    end else if (clk_en) begin
      host_ready_reg   <= ready_next;
      sw_prev_reg      <= sw_sync_reg;
      setting_prev_reg <= setting_reg;
      ready_prev_reg   <= host_ready_reg;
    end
  end

  logic rdy_rise;
  logic rdy_fall;
  assign rdy_rise = host_ready_reg & ~ready_prev_reg;
  assign rdy_fall = ~host_ready_reg & ready_prev_reg;

  // ==========================================================
  // edge sequencer
  crg_state_t state_reg;
  crg_state_t state_next;
  logic       start_err;

  always_comb begin
    state_next = state_reg;
    start_err  = 1'b0;
    case (state_reg)
      CRG_ST_OFF: begin
        if (rdy_rise) begin
          if (test_mode_flag) begin
            state_next = CRG_ST_DEFER;
          end else if (axis_busy) begin
            start_err = 1'b1;
          end else begin
            state_next = CRG_ST_CLEAR;
          end
        end
      end
      CRG_ST_DEFER: begin
        if (!host_ready_reg) begin
          state_next = CRG_ST_OFF;
        end else if (!test_mode_flag) begin
          if (axis_busy) begin
            start_err  = 1'b1;
            state_next = CRG_ST_OFF;
          end else begin
            state_next = CRG_ST_CLEAR;
          end
        end
      end
      CRG_ST_CLEAR: begin
        state_next = host_ready_reg ? CRG_ST_RUN : CRG_ST_OFF;
      end
      CRG_ST_RUN: begin
        if (!host_ready_reg) begin
          state_next = CRG_ST_OFF;
        end
      end
      default: begin
        state_next = CRG_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CRG_ST_OFF;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  logic enter_run;
  assign enter_run = (state_reg == CRG_ST_CLEAR) && host_ready_reg;

  // ==========================================================
  // action pulses and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcode_clear                <= 1'b0;
      auto_start                 <= 1'b0;
      decel_stop                 <= 1'b0;
      prog_halt                  <= 1'b0;
      motion_ready_complete_flag <= 1'b0;
      motion_enable              <= 1'b0;
      host_ready_flag            <= 1'b0;
    end else if (clk_en) begin
      mcode_clear <= (state_next == CRG_ST_CLEAR) && (state_reg != CRG_ST_CLEAR);
      auto_start  <= enter_run;
      decel_stop  <= rdy_fall;
      prog_halt   <= rdy_fall;
      motion_enable   <= host_ready_reg & ~test_mode_flag & (state_reg == CRG_ST_RUN);
      host_ready_flag <= host_ready_reg;
      if (rdy_fall || !host_ready_reg) begin
        motion_ready_complete_flag <= 1'b0;
      end else if (enter_run) begin
        motion_ready_complete_flag <= 1'b1;
      end
    end
  end

  // ==========================================================
  // real outputs and parameters
  logic param_wr;
  logic param_refuse;
  // writes refused while ready
  // access obeys the setup answer, so a flag change mid-transfer cannot split them
  assign param_wr     = wr_acc && paddr == CRG_OFF_PARAM && !pslverr;
  assign param_refuse = setup_ph && pwrite && paddr == CRG_OFF_PARAM && host_ready_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_param        <= CRG_PARAM_RST;
      real_output_points <= CRG_OUT_RST;
    end else if (clk_en) begin
      if (param_wr) begin
        fixed_param <= pwdata;
      end
      if (rdy_fall) begin
        real_output_points <= CRG_OUT_RST;
      end else if (wr_acc && paddr == CRG_OFF_OUTPUTS) begin
        real_output_points <= pwdata[CRG_OUT_W-1:0];
      end
    end
  end

  // ==========================================================
  // interrupt status
  logic [CRG_IRQ_W-1:0] irq_st_reg;
  logic [CRG_IRQ_W-1:0] irq_evt;
  logic [CRG_IRQ_W-1:0] irq_clr;

  assign irq_evt[CRG_IRQ_RISE]      = auto_start;
  assign irq_evt[CRG_IRQ_FALL]      = rdy_fall;
  assign irq_evt[CRG_IRQ_START_ERR] = start_err;
  assign irq_evt[CRG_IRQ_PARAM_REF] = param_refuse;
  assign irq_clr = (wr_acc && paddr == CRG_OFF_IRQ_ST) ? pwdata[CRG_IRQ_W-1:0] : '0;

  // set beats clear in the same cycle so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < CRG_IRQ_W; gi++) begin : g_irq
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_st_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          if (irq_evt[gi]) begin
            irq_st_reg[gi] <= 1'b1;
          end else if (irq_clr[gi]) begin
            irq_st_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_st_reg & irq_mask_reg & ~irq_clr | irq_evt & irq_mask_reg);
    end
  end

  // ==========================================================
  // apb answer, registered in setup so access ends in one cycle
  crg_status_t st;
  logic [31:0] rd_mux;

  always_comb begin
    st.run_switch     = sw_sync_reg;
    st.deferred       = (state_reg == CRG_ST_DEFER);
    st.test_mode      = test_mode_flag;
    st.motion_enable  = motion_enable;
    st.ready_complete = motion_ready_complete_flag;
    st.host_ready     = host_ready_reg;
    rd_mux = 32'h0000_0000;
    case (paddr)
      CRG_OFF_CTRL:    rd_mux[CRG_CTRL_MODE_BIT] = mode_alt_reg;
      CRG_OFF_STATUS:  rd_mux[$bits(crg_status_t)-1:0] = st;
      CRG_OFF_IRQ_ST:  rd_mux[CRG_IRQ_W-1:0] = irq_st_reg;
      CRG_OFF_IRQ_MSK: rd_mux[CRG_IRQ_W-1:0] = irq_mask_reg;
      CRG_OFF_PARAM:   rd_mux = fixed_param;
      CRG_OFF_OUTPUTS: rd_mux[CRG_OUT_W-1:0] = real_output_points;
      CRG_OFF_SETTING: rd_mux[CRG_SET_BIT] = setting_reg;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= setup_ph;
      // unmapped address or refused parameter write answers with error
      pslverr <= setup_ph && (!addr_hit || param_refuse);
      prdata  <= rd_acc ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // crg_gate

// ==== verif/crg_gate_assertions.sv ====
// checker for the ready gate sequencing
// assumes binding to crg_gate with clk_en held high
`timescale 1ns/1ps
module crg_gate_assertions
  import crg_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 clk_en,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 test_mode_flag,
  input wire logic                 axis_busy,
  input wire logic                 host_ready_flag,
  input wire logic                 motion_ready_complete_flag,
  input wire logic                 motion_enable,
  input wire logic                 mcode_clear,
  input wire logic                 auto_start,
  input wire logic                 decel_stop,
  input wire logic                 prog_halt,
  input wire logic [CRG_OUT_W-1:0] real_output_points
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // ready edges
  sequence s_quiet_rise;
    (!test_mode_flag && !axis_busy)[*3] ##0 $rose(host_ready_flag);
  endsequence
  sequence s_busy_rise;
    axis_busy[*2] ##0 $rose(host_ready_flag);
  endsequence
  sequence s_test_rise;
    test_mode_flag[*3] ##0 $rose(host_ready_flag);
  endsequence
  // past presetn keeps the reset drop of the flag out
  sequence s_fall;
    $fell(host_ready_flag) && $past(presetn);
  endsequence
  // ==========================================================
  // properties
  chk_pready_next: assert property (psel && !penable && clk_en |=> pready)
    else $error("no answer after setup");
  // aux clear lands with the visible flag rise, start and complete one cycle later
  chk_rise_steps: assert property (s_quiet_rise |->
    mcode_clear ##1 (auto_start && motion_ready_complete_flag))
    else $error("rise steps out of order");
  chk_busy_skips: assert property (s_busy_rise |-> !mcode_clear [*3])
    else $error("rise processed with axis moving");
  chk_test_defers: assert property (s_test_rise |-> !mcode_clear)
    else $error("rise processed in test mode");
  chk_enable_cause: assert property ($rose(motion_enable) |-> host_ready_flag && !$past(test_mode_flag))
    else $error("motion enabled without ready");
  chk_test_blocks: assert property (test_mode_flag ##1 test_mode_flag |-> !motion_enable)
    else $error("motion enabled in test mode");
  chk_fall_actions: assert property (s_fall |-> decel_stop && prog_halt
    && !motion_ready_complete_flag && real_output_points == '0)
    else $error("fall actions missing");
  chk_param_refused: assert property (psel && !penable && pwrite
    && paddr == CRG_OFF_PARAM && host_ready_flag |=> pslverr)
    else $error("parameter write not refused");
endmodule // crg_gate_assertions

bind crg_gate crg_gate_assertions u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pready,
  .pslverr, .test_mode_flag, .axis_busy, .host_ready_flag, .motion_ready_complete_flag, .motion_enable,
  .mcode_clear, .auto_start, .decel_stop, .prog_halt, .real_output_points);

// ==== verif/crg_host_model.sv ====
// host side model: run/stop switch and one axis
// assumes commands come from the bench on pclk
`timescale 1ns/1ps
module crg_host_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic switch_cmd,
  input  wire logic jog_req,
  input  wire logic motion_enable,
  input  wire logic decel_stop,
  output logic      run_switch,
  output logic      axis_busy
);
  logic [5:0] coast_reg;
  // ==========================================================
  // switch
  // host drives the run/stop switch
  // contacts settle off the clock grid, hence the odd delay
  assign #1.7 run_switch = switch_cmd;
  // ==========================================================
  // axis
  // own state only
  // a stopped axis coasts 40 cycles, long enough to catch a quick restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_busy <= 1'b0;
      coast_reg <= 6'h00;
    end else if (jog_req && motion_enable) begin
      axis_busy <= 1'b1;
    end else if (decel_stop && axis_busy) begin
      coast_reg <= 6'h28;
    end else if (coast_reg != 6'h00) begin
      coast_reg <= coast_reg - 6'h01;
      axis_busy <= (coast_reg != 6'h01);
    end
  end
endmodule // crg_host_model

// ==== verif/controller_ready_gate_bench.sv ====
// self-checking bench for the ready gate
// assumes crg_gate, the checker and the host model are compiled first
`timescale 1ns/1ps
module controller_ready_gate_bench;
  import crg_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, fixed_param, p;
  logic run_switch, test_mode_flag, axis_busy, switch_cmd, jog_req;
  logic host_ready_flag, motion_ready_complete_flag, motion_enable;
  logic mcode_clear, auto_start, decel_stop, prog_halt;
  logic [CRG_OUT_W-1:0] real_output_points;
  int fail_count, compares, n_clear, n_start, n_decel, k;
  crg_gate DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .run_switch, .test_mode_flag, .axis_busy, .host_ready_flag, .motion_ready_complete_flag, .motion_enable,
    .mcode_clear, .auto_start, .decel_stop, .prog_halt, .real_output_points, .fixed_param, .irq);
  crg_host_model u_host (.pclk, .presetn, .switch_cmd, .jog_req, .motion_enable, .decel_stop, .run_switch,
    .axis_busy);
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    n_clear += (mcode_clear === 1'b1);
    n_start += (auto_start === 1'b1);
    n_decel += (decel_stop === 1'b1);
  end
  // ==========================================================
  // checks and bus
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: bit %b, want %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: word %h, want %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] st(input logic [5:0] b);
    return {26'h0, b};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] ed, input logic ee);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a missing answer counts as a mismatch
    chk_bit(pready, 1'b1);
    if (!w) chk_word(prdata, ed);
    chk_bit(pslverr, ee);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_flag(input logic v);
    for (k = 0; k < 60 && host_ready_flag !== v; k++) @(posedge pclk);
    chk_bit(host_ready_flag, v);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    tally_and_finish;
  end
  // ==========================================================
  // tests
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, switch_cmd, jog_req, test_mode_flag} = '0;
    clk_en = 1'b1;
    void'($urandom(32'hb467cb32));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, CRG_OFF_STATUS, 0, st(6'h00), 0);
    apb(0, CRG_OFF_PARAM, 0, CRG_PARAM_RST, 0);
    apb(0, CRG_OFF_IRQ_MSK, 0, {28'h0, CRG_MSK_RST}, 0);
    apb(0, 8'h3c, 0, 32'h0, 1);
    p = $urandom;
    apb(1, CRG_OFF_PARAM, p, 0, 0);
    // the write lands at the access edge, so look one edge later
    @(posedge pclk);
    chk_word(fixed_param, p);
    apb(1, CRG_OFF_OUTPUTS, $urandom, 0, 0);
    apb(1, CRG_OFF_IRQ_MSK, 32'h1, 0, 0);
    $display("test registers done");
    switch_cmd <= 1'b1;
    wait_flag(1);
    repeat (6) @(posedge pclk);
    chk_word(n_clear + n_start, 2);
    apb(0, CRG_OFF_STATUS, 0, st(6'h27), 0);
    chk_bit(irq, 1);
    apb(1, CRG_OFF_PARAM, ~p, 0, 1);
    apb(0, CRG_OFF_PARAM, 0, p, 0);
    apb(1, CRG_OFF_IRQ_ST, 32'hf, 0, 0);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 0);
    jog_req <= 1'b1;
    @(posedge pclk);
    jog_req <= 1'b0;
    $display("test rise done");
    switch_cmd <= 1'b0;
    wait_flag(0);
    repeat (2) @(posedge pclk);
    chk_word(n_decel, 1);
    chk_word(real_output_points, 0);
    chk_bit(motion_ready_complete_flag, 0);
    switch_cmd <= 1'b1;
    wait_flag(1);
    repeat (6) @(posedge pclk);
    chk_bit(motion_ready_complete_flag, 0);
    apb(0, CRG_OFF_IRQ_ST, 0, 32'h6, 0);
    $display("test fall and busy done");
    switch_cmd <= 1'b0;
    for (k = 0; k < 100 && axis_busy !== 1'b0; k++) @(posedge pclk);
    test_mode_flag <= 1'b1;
    switch_cmd <= 1'b1;
    wait_flag(1);
    repeat (6) @(posedge pclk);
    apb(0, CRG_OFF_STATUS, 0, st(6'h39), 0);
    test_mode_flag <= 1'b0;
    repeat (6) @(posedge pclk);
    chk_bit(motion_ready_complete_flag, 1);
    chk_bit(motion_enable, 1);
    $display("test deferral done");
    switch_cmd <= 1'b0;
    wait_flag(0);
    apb(1, CRG_OFF_CTRL, 32'h1, 0, 0);
    switch_cmd <= 1'b1;
    repeat (10) @(posedge pclk);
    chk_bit(host_ready_flag, 0);
    apb(1, CRG_OFF_SETTING, 32'h1, 0, 0);
    wait_flag(1);
    apb(1, CRG_OFF_SETTING, 32'h0, 0, 0);
    wait_flag(0);
    apb(1, CRG_OFF_SETTING, 32'h1, 0, 0);
    wait_flag(1);
    switch_cmd <= 1'b0;
    wait_flag(0);
    apb(1, CRG_OFF_SETTING, 32'h0, 0, 0);
    apb(1, CRG_OFF_SETTING, 32'h1, 0, 0);
    switch_cmd <= 1'b1;
    repeat (10) @(posedge pclk);
    chk_bit(host_ready_flag, 0);
    $display("test setting mode done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_flag(1);
    $display("test power-up in run done");
    tally_and_finish;
  end
endmodule // controller_ready_gate_bench
